// [rtl/crc_pkg.sv]
`default_nettype none
package crc_pkg;
  // ==========================================================
  // Register indices, byte address is index times four
  localparam int ADDR_W = 8;
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_CCTRL = 8'h02;
  localparam logic [7:0] IDX_DIN = 8'h04;
  localparam logic [7:0] IDX_SUM = 8'h08;
  localparam logic [7:0] IDX_STAT = 8'h0c;
  localparam logic [7:0] IDX_IST = 8'h10;
  localparam logic [7:0] IDX_IMSK = 8'h11;
  // ==========================================================
  // Field positions
  localparam int EN_BIT = 2;
  localparam int SRC_LSB = 8;
  localparam int SRC_W = 6;
  localparam int POLY_LSB = 2;
  localparam int BEAT_LSB = 0;
  localparam int BUSY_BIT = 0;
  localparam int ZERO_BIT = 1;
  localparam int EV_DONE = 0;
  localparam int EV_ZERO = 1;
  localparam int EV_W = 2;
  // ==========================================================
  // Codes and constants
  localparam logic [5:0] SRC_NONE = 6'h00;
  localparam logic [5:0] SRC_IO = 6'h01;
  localparam int SRC_CH_BIT = 5;
  localparam logic [1:0] POLY16 = 2'h0;
  localparam logic [1:0] POLY32 = 2'h1;
  localparam logic [1:0] BEAT8 = 2'h0;
  localparam logic [1:0] BEAT16 = 2'h1;
  localparam logic [1:0] BEAT32 = 2'h2;
  localparam logic [15:0] GEN16 = 16'h1021;
  localparam logic [31:0] GEN32 = 32'h04c1_1db7;
  localparam logic [15:0] CCTRL_RST = 16'h0000;
  localparam logic [31:0] SUM_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage
`default_nettype wire

// [rtl/dma_crc_checksum_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_crc_checksum_unit (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [crc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [31:0] i_ch_enable,
  input wire logic i_beat_valid,
  input wire logic [4:0] i_beat_ch,
  input wire logic [31:0] i_beat_data,
  input wire logic [1:0] i_beat_width,
  output logic o_irq,
  output logic o_busy,
  output logic o_enable
);
  import crc_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == {idx[5:0], 2'b00});
  endfunction

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b,
                                           input logic p32);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (p32) begin
        fb = r[31] ^ b[i];
        r = {r[30:0], 1'b0} ^ (fb ? GEN32 : ZERO32);
      end else begin
        fb = r[15] ^ b[i];
        r = {ZERO16, r[14:0], 1'b0} ^ {ZERO16, (fb ? GEN16 : ZERO16)};
      end
    end
    crc_byte = r;
  endfunction

  // Bytes taken low lane first
  function automatic logic [31:0] crc_beat(input logic [31:0] c,
                                           input logic [31:0] d,
                                           input logic [1:0] w,
                                           input logic p32);
    logic [31:0] r;
    r = c;
    for (int k = 0; k < 4; k++) begin
      if (k == 0 || (k == 1 && w != BEAT8) ||
          (k > 1 && w != BEAT8 && w != BEAT16)) begin
        r = crc_byte(r, d[8*k +: 8], p32);
      end
    end
    crc_beat = r;
  endfunction

  function automatic logic [31:0] rev32(input logic [31:0] v);
    for (int i = 0; i < 32; i++) begin
      rev32[i] = v[31-i];
    end
  endfunction

  // ==========================================================
  // State
  logic en_r;
  logic [SRC_W-1:0] src_r;
  logic [1:0] poly_r;
  logic [1:0] beat_r;
  logic [31:0] din_r;
  logic [31:0] sum_r;
  logic busy_r;
  logic busy_nxt;
  logic zero_r;
  logic pend_r;
  logic [1:0] cnt_r;
  logic [EV_W-1:0] ist_r;
  logic [EV_W-1:0] imsk_r;
  logic irq_r;

  logic p32;
  logic src_ch;
  logic ch_on;
  logic xfer;
  logic wr;
  logic rd;
  logic stall;
  logic rdy_nxt;
  logic din_wr;
  logic io_wr;
  logic sum_wr;
  logic cc_wr;
  logic src_chg;
  logic done;
  logic dma_beat;
  logic mapped;
  logic [31:0] rd_nxt;
  logic [31:0] sum_view;

  assign p32 = (poly_r == POLY32);
  assign src_ch = src_r[SRC_CH_BIT];
  assign ch_on = i_ch_enable[src_r[4:0]];
  assign xfer = o_pready & i_psel & i_penable;
  assign wr = xfer & i_pwrite;
  assign rd = xfer & ~i_pwrite;
  assign stall = i_pwrite & hit(i_paddr, IDX_DIN) & pend_r;
  assign rdy_nxt = i_psel & i_penable & ~o_pready & ~stall;
  assign din_wr = wr & hit(i_paddr, IDX_DIN);
  assign io_wr = din_wr & en_r & (src_r == SRC_IO);
  assign sum_wr = wr & hit(i_paddr, IDX_SUM) & ~en_r;
  assign cc_wr = wr & hit(i_paddr, IDX_CCTRL) &
                 ~en_r & ~busy_r;
  assign src_chg = cc_wr &
                   (i_pwdata[SRC_LSB +: SRC_W] != src_r);
  assign dma_beat = en_r & src_ch & ch_on & i_beat_valid &
                    (i_beat_ch == src_r[4:0]);
  assign done = busy_r & ~busy_nxt;
  assign mapped = hit(i_paddr, IDX_CTRL) | hit(i_paddr, IDX_CCTRL) |
                  hit(i_paddr, IDX_DIN) | hit(i_paddr, IDX_SUM) |
                  hit(i_paddr, IDX_STAT) | hit(i_paddr, IDX_IST) |
                  hit(i_paddr, IDX_IMSK);

  // ==========================================================
  // Busy flag
  always_comb begin
    busy_nxt = 1'b0;
    if (en_r && src_ch) begin
      busy_nxt = ch_on;
    end else if (en_r && src_r == SRC_IO) begin
      busy_nxt = io_wr | (busy_r & ~(wr & hit(i_paddr, IDX_STAT) &
                 i_pwdata[BUSY_BIT]));
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // ==========================================================
  // Enable and control
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_r <= 1'b0;
    end else if (wr && hit(i_paddr, IDX_CTRL)) begin
      if (i_pwdata[EN_BIT]) begin
        en_r <= 1'b1;
      end else if (!busy_r) begin
        en_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      src_r <= CCTRL_RST[SRC_LSB +: SRC_W];
      poly_r <= CCTRL_RST[POLY_LSB +: 2];
      beat_r <= CCTRL_RST[BEAT_LSB +: 2];
    end else if (cc_wr) begin
      src_r <= i_pwdata[SRC_LSB +: SRC_W];
      poly_r <= i_pwdata[POLY_LSB +: 2];
      beat_r <= i_pwdata[BEAT_LSB +: 2];
    end
  end

  // ==========================================================
  // Engine
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      din_r <= SUM_RST;
      pend_r <= 1'b0;
      cnt_r <= BEAT8;
    end else begin
      if (din_wr) begin
        din_r <= i_pwdata;
      end
      if (io_wr) begin
        pend_r <= 1'b1;
        cnt_r <= beat_r;
      end else if (pend_r && cnt_r != BEAT8) begin
        cnt_r <= cnt_r - 2'd1;
      end else begin
        pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sum_r <= SUM_RST;
    end else if (sum_wr) begin
      sum_r <= i_pwdata;
    end else if (pend_r && cnt_r == BEAT8) begin
      sum_r <= crc_beat(sum_r, din_r, beat_r, p32);
    end else if (dma_beat) begin
      sum_r <= crc_beat(sum_r, i_beat_data, i_beat_width, p32);
    end
  end

  // ==========================================================
  // Zero flag and interrupts
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      zero_r <= 1'b0;
    end else if (done && sum_r == ZERO32) begin
      zero_r <= 1'b1;
    end else if (src_chg) begin
      zero_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ist_r <= '0;
      imsk_r <= '0;
      irq_r <= 1'b0;
    end else begin
      for (int e = 0; e < EV_W; e++) begin
        if ((e == EV_DONE && done) ||
            (e == EV_ZERO && done && sum_r == ZERO32)) begin
          ist_r[e] <= 1'b1;
        end else if (rd && hit(i_paddr, IDX_IST)) begin
          ist_r[e] <= 1'b0;
        end
      end
      if (wr && hit(i_paddr, IDX_IMSK)) begin
        imsk_r <= i_pwdata[EV_W-1:0];
      end
      irq_r <= |(ist_r & imsk_r);
    end
  end

  // ==========================================================
  // APB read side
  always_comb begin
    sum_view = sum_r;
    if (!p32) begin
      sum_view = {ZERO16, sum_r[15:0]};
    end else if (!busy_r) begin
      sum_view = ~rev32(sum_r);
    end
    rd_nxt = ZERO32;
    if (hit(i_paddr, IDX_CTRL)) begin
      rd_nxt[EN_BIT] = en_r;
    end else if (hit(i_paddr, IDX_CCTRL)) begin
      rd_nxt[SRC_LSB +: SRC_W] = src_r;
      rd_nxt[POLY_LSB +: 2] = poly_r;
      rd_nxt[BEAT_LSB +: 2] = beat_r;
    end else if (hit(i_paddr, IDX_DIN)) begin
      rd_nxt = din_r;
    end else if (hit(i_paddr, IDX_SUM)) begin
      rd_nxt = sum_view;
    end else if (hit(i_paddr, IDX_STAT)) begin
      rd_nxt[BUSY_BIT] = busy_r;
      rd_nxt[ZERO_BIT] = zero_r;
    end else if (hit(i_paddr, IDX_IST)) begin
      rd_nxt[EV_W-1:0] = ist_r;
    end else if (hit(i_paddr, IDX_IMSK)) begin
      rd_nxt[EV_W-1:0] = imsk_r;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= ZERO32;
    end else begin
      o_pready <= rdy_nxt;
      o_pslverr <= rdy_nxt & ~mapped;
      if (rdy_nxt && !i_pwrite) begin
        o_prdata <= rd_nxt;
      end
    end
  end

  assign o_irq = irq_r;
  assign o_busy = busy_r;
  assign o_enable = en_r;

  // ==========================================================
  // Checks
  a_src_lock: assert property (
    @(posedge i_clk) disable iff (i_rst) busy_r |=> $stable(src_r))
    else $error("source changed while busy");
  a_busy_en: assert property (
    @(posedge i_clk) disable iff (i_rst) !en_r |=> !busy_r)
    else $error("busy without enable");
  a_ch_follow: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (en_r && src_ch) |=> busy_r == $past(ch_on))
    else $error("busy does not follow channel");
  a_beat_lat: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (io_wr && beat_r == BEAT16) |=> pend_r ##1 pend_r ##1 !pend_r)
    else $error("beat latency wrong");
  a_sum_prot: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr && hit(i_paddr, IDX_SUM) && en_r && !pend_r && !dma_beat)
    |=> $stable(sum_r))
    else $error("checksum written while enabled");
  a_rd_rev: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (rdy_nxt && !i_pwrite && hit(i_paddr, IDX_SUM) && p32 && !busy_r)
    |=> o_prdata == ~rev32($past(sum_r)))
    else $error("crc32 readback wrong");
  a_rd_hi16: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (rdy_nxt && !i_pwrite && hit(i_paddr, IDX_SUM) && !p32)
    |=> o_prdata[31:16] == ZERO16)
    else $error("crc16 upper half not zero");
  a_en_hold: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (busy_r && wr && hit(i_paddr, IDX_CTRL)) |=> en_r)
    else $error("disabled while busy");
  a_cc_prot: assert property (
    @(posedge i_clk) disable iff (i_rst)
    en_r |=> $stable(poly_r) && $stable(beat_r))
    else $error("control changed while enabled");
  a_zero_clr: assert property (
    @(posedge i_clk) disable iff (i_rst) (src_chg && !done) |=> !zero_r)
    else $error("zero flag kept on new source");
  c_io_done: cover property (@(posedge i_clk) disable iff (i_rst)
    done && src_r == SRC_IO);
  c_ch_done: cover property (@(posedge i_clk) disable iff (i_rst)
    done && src_ch);
  c_zero: cover property (@(posedge i_clk) disable iff (i_rst)
    $rose(zero_r));
endmodule
`default_nettype wire

// [tb/dma_channel_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_channel_model (
  input wire logic i_clk,
  output logic [31:0] o_ch_enable,
  output logic o_beat_valid,
  output logic [4:0] o_beat_ch,
  output logic [31:0] o_beat_data,
  output logic [1:0] o_beat_width
);
  initial begin
    o_ch_enable = 32'h0000_0000;
    o_beat_valid = 1'b0;
    o_beat_ch = 5'h00;
    o_beat_data = 32'h0000_0000;
    o_beat_width = 2'h0;
  end
  // ==========================================================
  // Channel enable and beat traffic
  task channel(input logic [4:0] ch, input logic on);
    @(posedge i_clk);
    o_ch_enable[ch] <= on;
  endtask
  // Channel and data lines turn to their inverse once a beat is over
  task beat(input logic [4:0] ch, input logic [31:0] d,
      input logic [1:0] w, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_beat_valid <= 1'b1;
    o_beat_ch <= ch;
    o_beat_data <= d;
    o_beat_width <= w;
    @(posedge i_clk);
    o_beat_valid <= 1'b0;
    o_beat_ch <= ~ch;
    o_beat_data <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/test_dma_crc_checksum_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dma_crc_checksum_unit;
  import crc_pkg::*;
  typedef struct packed {logic [31:0] d; logic e; logic rd;} note_t;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, ch_en, b_data, sum, cfg, w;
  logic pready, pslverr, irq, busy, enable, b_valid;
  logic [4:0] b_ch;
  logic [1:0] b_width;
  logic [15:0] lfsr = 16'hb2b1;
  note_t notes[$];
  note_t n;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 i_clk = ~i_clk;
  dma_crc_checksum_unit dma_crc_checksum_unit_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ch_enable(ch_en), .i_beat_valid(b_valid), .i_beat_ch(b_ch),
    .i_beat_data(b_data), .i_beat_width(b_width), .o_irq(irq),
    .o_busy(busy), .o_enable(enable)
  );
  dma_channel_model dma_channel_model_i (
    .i_clk(i_clk), .o_ch_enable(ch_en), .o_beat_valid(b_valid),
    .o_beat_ch(b_ch), .o_beat_data(b_data), .o_beat_width(b_width)
  );
  // ==========================================================
  // Reference model and bus tasks
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [31:0] crc(logic [31:0] c, logic [31:0] d,
      int nb, bit p32);
    logic fb;
    for (int i = 0; i < nb * 8; i++) begin
      fb = (p32 ? c[31] : c[15]) ^ d[i];
      c = c << 1;
      if (fb) c ^= p32 ? GEN32 : {16'h0000, GEN16};
    end
    return p32 ? c : {16'h0000, c[15:0]};
  endfunction
  function automatic logic [31:0] seen(logic [31:0] c);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = c[31 - i];
    return ~r;
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(bit is_wr, logic [7:0] a, logic [31:0] d, logic [31:0] x,
      logic e);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    notes.push_back('{x, e, !is_wr});
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(logic [7:0] i, logic [31:0] d);
    apb(1'b1, i << 2, d, 32'h0, 1'b0);
  endtask
  task rd(logic [7:0] i, logic [31:0] x);
    apb(1'b0, i << 2, 32'h0, x, 1'b0);
  endtask
  always @(posedge i_clk) begin
    if (pready === 1'b1) begin
      n = notes.pop_front();
      check(pslverr, n.e);
      if (n.rd) check(prdata, n.d);
    end
  end
  task complete_run();
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end
  // ==========================================================
  // Processor-fed computation
  task io_run(bit p, logic [1:0] b, logic [31:0] pre, logic [31:0] m);
    cfg = {18'h0, SRC_IO, 4'h0, 1'b0, p, b};
    wr(IDX_CCTRL, cfg);
    wr(IDX_SUM, pre);
    sum = crc(pre, 32'h0, 0, p);
    wr(IDX_CTRL, 32'h0000_0004);
    for (int k = 0; k < 2; k++) begin
      w = {rnd(), rnd()} & m;
      wr(IDX_DIN, w);
      sum = crc(sum, w, 1 << b, p);
    end
    repeat (b + 2) @(posedge i_clk);
    check(busy, 1'b1);
    check(enable, 1'b1);
    wr(IDX_SUM, ~pre);
    wr(IDX_CCTRL, 32'h0);
    wr(IDX_CTRL, 32'h0);
    rd(IDX_SUM, sum);
    rd(IDX_CCTRL, cfg);
    rd(IDX_CTRL, 32'h0000_0004);
    wr(IDX_STAT, 32'h0000_0001);
    rd(IDX_STAT, {30'h0, sum == 32'h0, 1'b0});
    check(irq, 1'b1);
    rd(IDX_IST, {30'h0, sum == 32'h0, 1'b1});
    rd(IDX_SUM, p ? seen(sum) : sum);
    wr(IDX_CTRL, 32'h0);
    rd(IDX_CTRL, 32'h0);
    check(irq, 1'b0);
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(IDX_CCTRL, CCTRL_RST);
    rd(IDX_SUM, SUM_RST);
    apb(1'b0, 8'hfc, 32'h0, 32'h0, 1'b1);
    wr(IDX_IMSK, 32'h0000_0003);
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 3; b++) begin
        io_run(1'(p), 2'(b), 32'hffff_ffff, 32'hffff_ffff);
      end
    end
    io_run(1'b1, BEAT32, 32'h0, 32'h0);
    wr(IDX_CCTRL, 32'h0);
    rd(IDX_STAT, 32'h0);
    // ========================================================
    // Channel-fed computation
    cfg = {18'h0, 6'h25, 4'h0, POLY32, BEAT8};
    wr(IDX_CCTRL, cfg);
    wr(IDX_SUM, 32'hffff_ffff);
    sum = 32'hffff_ffff;
    wr(IDX_IMSK, 32'h0);
    wr(IDX_CTRL, 32'h0000_0004);
    dma_channel_model_i.channel(5'h05, 1'b1);
    repeat (2) @(posedge i_clk);
    wr(IDX_STAT, 32'h0000_0001);
    check(busy, 1'b1);
    for (int k = 0; k < 3; k++) begin
      w = {rnd(), rnd()};
      dma_channel_model_i.beat(5'h05, w, 2'(k), k);
      dma_channel_model_i.beat(5'h06, ~w, BEAT32, 0);
      sum = crc(sum, w, 1 << k, 1'b1);
    end
    rd(IDX_SUM, sum);
    wr(IDX_CCTRL, 32'h0);
    rd(IDX_CCTRL, cfg);
    dma_channel_model_i.channel(5'h05, 1'b0);
    repeat (2) @(posedge i_clk);
    check(busy, 1'b0);
    rd(IDX_SUM, seen(sum));
    check(irq, 1'b0);
    wr(IDX_IMSK, 32'h0000_0003);
    repeat (2) @(posedge i_clk);
    check(irq, 1'b1);
    rd(IDX_IST, {30'h0, sum == 32'h0, 1'b1});
    repeat (2) @(posedge i_clk);
    check(irq, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
